// file: design/fbc_defines.svh
// constants for the four bit up/down counter
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH
`define FBC_W 4
`define FBC_ZERO 4'h0
`define FBC_ONE 4'h1
`define FBC_BIN_MAX 4'hf
`define FBC_DEC_MAX 4'h9
`endif

// file: design/fbc_pkg.sv
// types shared by the four bit up/down counter
package fbc_pkg;
	// control inputs sampled at each rising clock edge
	typedef struct packed {
		logic parallel_load;
		logic count_enable_in;
		logic count_up_not_down;
	} fbc_ctrl_t;

	// action taken at the next edge, gray coded along hold-load-up-down
	typedef enum logic [1:0] {
		FBC_HOLD = 2'h0,
		FBC_LOAD = 2'h1,
		FBC_STEP_UP = 2'h3,
		FBC_STEP_DN = 2'h2
	} fbc_mode_t;
endpackage : fbc_pkg

// file: design/fbc_counter.sv
// configurable four bit binary or decade up/down counter
//
// Functional notes
// (R1) four flops hold count, combinational next state
// (R2) clear low forces count and carry low
// (R3) count advances one step per rising edge
// (R4) decade mode counts 0 to 9, wraps
// (R5) decade up/down wraps between 0 and 9
// (R6) direction high counts up, low counts down
// (R7) clear and load high copy load value
// (R8) load bit n lands on count bit n
// (R9) user drops load; counting resumes from value
// (R10) load wins over enable and holding
// (R11) count only when enable high, load low
// (R12) enable and load low hold the count
// (R13) decade carry high while 9, enabled and counting up
// (R14) binary carry at all ones up, zeros down
// (R15) binary wraps 15 to 0 and 0 to 15
// (R16) binary up-only carry on sixteenth count
// (R17) variant chosen by module parameters
`timescale 1ns/1ps
`include "fbc_defines.svh"

module fbc_counter #(
	parameter bit DECADE = 1'b0,
	parameter bit UPDOWN = 1'b1,
	parameter bit HAS_LOAD = 1'b1,
	parameter bit HAS_ENABLE = 1'b1,
	parameter bit HAS_CARRY = 1'b1
) (
	// clock and resets
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic clear_n_i,
	// control and load data
	input wire fbc_pkg::fbc_ctrl_t ctrl_i,
	input wire logic [`FBC_W-1:0] load_value_i,
	// count and carry
	output logic [`FBC_W-1:0] count_value_o,
	output logic terminal_count_out_o
);

	logic [`FBC_W-1:0] count_r;
	logic [`FBC_W-1:0] count_nxt;
	logic [`FBC_W-1:0] top_val;
	logic load_eff;
	logic enable_eff;
	logic up_eff;
	logic at_term;
	fbc_pkg::fbc_mode_t mode;

	// unused features are tied off by configuration
	assign load_eff = HAS_LOAD & ctrl_i.parallel_load; // see (R17)
	assign enable_eff = HAS_ENABLE ? ctrl_i.count_enable_in : 1'b1;
	assign up_eff = UPDOWN ? ctrl_i.count_up_not_down : 1'b1; // see (R6)
	assign top_val = DECADE ? `FBC_DEC_MAX : `FBC_BIN_MAX;

	// load first, then counting, else hold
	always_comb begin
		if (load_eff) begin
			mode = fbc_pkg::FBC_LOAD; // see (R10)
		end else if (enable_eff) begin
			mode = up_eff ? fbc_pkg::FBC_STEP_UP : fbc_pkg::FBC_STEP_DN; // see (R11)
		end else begin
			mode = fbc_pkg::FBC_HOLD; // see (R12)
		end
	end

	// next state; loaded decade values above 9 re-enter the 0..9 ring
	always_comb begin
		case (mode)
			fbc_pkg::FBC_LOAD: begin
				count_nxt = load_value_i; // see (R7) see (R8)
			end
			fbc_pkg::FBC_STEP_UP: begin
				if (count_r >= top_val) begin
					count_nxt = `FBC_ZERO; // see (R4) see (R15)
				end else begin
					count_nxt = count_r + `FBC_ONE; // see (R3)
				end
			end
			fbc_pkg::FBC_STEP_DN: begin
				if (count_r == `FBC_ZERO || count_r > top_val) begin
					count_nxt = top_val; // see (R5) see (R15)
				end else begin
					count_nxt = count_r - `FBC_ONE;
				end
			end
			fbc_pkg::FBC_HOLD: begin
				count_nxt = count_r;
			end
			default: begin
				count_nxt = count_r;
			end
		endcase
	end

	// four d flops, asynchronously cleared
	always_ff @(posedge clk_sys_i or negedge clear_n_i) begin
		if (!clear_n_i) begin
			count_r <= `FBC_ZERO; // see (R2)
		end else if (reset_i) begin
			count_r <= `FBC_ZERO;
		end else begin
			count_r <= count_nxt; // see (R1) see (R9)
		end
	end

	assign count_value_o = count_r;

	// terminal value: top when counting up, zero for binary down
	always_comb begin
		if (mode == fbc_pkg::FBC_STEP_UP) begin
			at_term = (count_r == top_val); // see (R13) see (R16)
		end else if (mode == fbc_pkg::FBC_STEP_DN) begin
			at_term = !DECADE && (count_r == `FBC_ZERO); // see (R14)
		end else begin
			at_term = 1'b0;
		end
	end

	// carry is gated by clear so it drops at once with it
	assign terminal_count_out_o = HAS_CARRY & clear_n_i & at_term; // see (R2)

	a_clear_zero: assert property ( // see (R2)
		@(posedge clk_sys_i)
		!clear_n_i |-> (count_value_o == `FBC_ZERO) && !terminal_count_out_o
	) else $error("count or carry not low while clear asserted");

	a_sync_reset: assert property (
		@(posedge clk_sys_i) disable iff (!clear_n_i)
		reset_i |=> (count_value_o == `FBC_ZERO)
	) else $error("count not zero after reset");

	a_load_copy: assert property ( // see (R7)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(HAS_LOAD && ctrl_i.parallel_load)
		|=> (count_value_o == $past(load_value_i))
	) else $error("load value not copied into count");

	a_load_wins: assert property ( // see (R10)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(HAS_LOAD && ctrl_i.parallel_load && !ctrl_i.count_enable_in)
		|=> (count_value_o == $past(load_value_i))
	) else $error("load ignored while enable low");

	a_hold_idle: assert property ( // see (R12)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(HAS_ENABLE && !ctrl_i.count_enable_in && !load_eff)
		|=> $stable(count_value_o)
	) else $error("count changed while disabled");

	a_step_up: assert property ( // see (R3)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(enable_eff && !load_eff && up_eff && count_value_o < top_val)
		|=> (count_value_o == $past(count_value_o) + `FBC_ONE)
	) else $error("up count did not advance by one");

	a_step_down: assert property ( // see (R6)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(UPDOWN && enable_eff && !load_eff && !ctrl_i.count_up_not_down
			&& count_value_o != `FBC_ZERO && count_value_o <= top_val)
		|=> (count_value_o == $past(count_value_o) - `FBC_ONE)
	) else $error("down count did not step back by one");

	a_wrap_up: assert property ( // see (R15)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(enable_eff && !load_eff && up_eff && count_value_o == top_val)
		|=> (count_value_o == `FBC_ZERO)
	) else $error("up count did not wrap to zero");

	a_wrap_down: assert property ( // see (R5)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(UPDOWN && enable_eff && !load_eff && !ctrl_i.count_up_not_down
			&& count_value_o == `FBC_ZERO)
		|=> (count_value_o == (DECADE ? `FBC_DEC_MAX : `FBC_BIN_MAX))
	) else $error("down count did not wrap to top value");

	a_dec_range: assert property ( // see (R4)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(DECADE && !load_eff && count_value_o <= `FBC_DEC_MAX)
		|=> (count_value_o <= `FBC_DEC_MAX)
	) else $error("decade count left the range 0 to 9");

	a_carry_dec: assert property ( // see (R13)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(HAS_CARRY && DECADE && enable_eff && !load_eff && up_eff
			&& count_value_o == `FBC_DEC_MAX)
		|-> terminal_count_out_o ##1 !terminal_count_out_o
	) else $error("decade carry not a single pulse at nine");

	a_carry_bin: assert property ( // see (R14)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(HAS_CARRY && !DECADE && enable_eff && !load_eff
			&& (up_eff ? count_value_o == `FBC_BIN_MAX
				: count_value_o == `FBC_ZERO))
		|-> terminal_count_out_o
	) else $error("binary carry missing at terminal value");

	a_carry_cause: assert property ( // see (R16)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		terminal_count_out_o
		|-> HAS_CARRY && enable_eff && !load_eff
			&& (count_value_o == top_val || count_value_o == `FBC_ZERO)
	) else $error("carry raised without terminal count");

	a_resume_load: assert property ( // see (R9)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(load_eff && load_value_i < top_val)
		##1 (enable_eff && !load_eff && up_eff)
		|=> (count_value_o == $past(load_value_i, 2) + `FBC_ONE)
	) else $error("count did not resume from loaded value");

	a_mode_load: assert property ( // see (R10)
		@(posedge clk_sys_i)
		load_eff |-> (mode == fbc_pkg::FBC_LOAD)
	) else $error("load did not take priority");

	a_load_next: assert property ( // see (R7)
		@(posedge clk_sys_i)
		(mode == fbc_pkg::FBC_LOAD) |-> (count_nxt == load_value_i)
	) else $error("next state is not the load value");

	a_load_bits: assert property ( // see (R8)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		load_eff
		|=> (count_value_o[0] == $past(load_value_i[0]))
			&& (count_value_o[3] == $past(load_value_i[3]))
	) else $error("load bits landed on wrong count bits");

	a_hold_next: assert property ( // see (R12)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(mode == fbc_pkg::FBC_HOLD) |=> $stable(count_value_o)
	) else $error("count moved while holding");

	a_carry_no_load: assert property ( // see (R10)
		@(posedge clk_sys_i)
		load_eff |-> !terminal_count_out_o
	) else $error("carry high during load");

	a_carry_no_enable: assert property ( // see (R11)
		@(posedge clk_sys_i)
		!enable_eff |-> !terminal_count_out_o
	) else $error("carry high while counting disabled");

	a_carry_dec_down: assert property ( // see (R13)
		@(posedge clk_sys_i)
		(DECADE && !up_eff) |-> !terminal_count_out_o
	) else $error("decade carry high while counting down");

	a_carry_dec_nine: assert property ( // see (R13)
		@(posedge clk_sys_i)
		(DECADE && terminal_count_out_o)
		|-> (count_value_o == `FBC_DEC_MAX)
	) else $error("decade carry away from nine");

	a_carry_up_top: assert property ( // see (R16)
		@(posedge clk_sys_i)
		(terminal_count_out_o && up_eff) |-> (count_value_o == top_val)
	) else $error("up carry away from top value");

	a_carry_down_zero: assert property ( // see (R14)
		@(posedge clk_sys_i)
		(terminal_count_out_o && !up_eff)
		|-> (!DECADE && count_value_o == `FBC_ZERO)
	) else $error("down carry away from zero");

	a_carry_clear: assert property ( // see (R2)
		@(posedge clk_sys_i)
		terminal_count_out_o |-> clear_n_i
	) else $error("carry high while clear asserted");

	a_dec_next_range: assert property ( // see (R4)
		@(posedge clk_sys_i)
		(DECADE && mode != fbc_pkg::FBC_LOAD && count_r <= `FBC_DEC_MAX)
		|-> (count_nxt <= `FBC_DEC_MAX)
	) else $error("decade next state above nine");

	a_dec_down_high: assert property ( // see (R5)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(DECADE && enable_eff && !load_eff && !up_eff
			&& count_value_o > `FBC_DEC_MAX)
		|=> (count_value_o == `FBC_DEC_MAX)
	) else $error("decade down from above nine missed nine");

	a_bin_up_wrap: assert property ( // see (R15)
		@(posedge clk_sys_i) disable iff (reset_i || !clear_n_i)
		(!DECADE && enable_eff && !load_eff && up_eff
			&& count_value_o == `FBC_BIN_MAX)
		|=> (count_value_o == `FBC_ZERO)
	) else $error("binary up count did not wrap to zero");

	a_dir_select: assert property ( // see (R6)
		@(posedge clk_sys_i)
		(enable_eff && !load_eff)
		|-> (mode == (up_eff ? fbc_pkg::FBC_STEP_UP
			: fbc_pkg::FBC_STEP_DN))
	) else $error("direction not taken from direction input");

endmodule : fbc_counter

// file: bench/fbc_user_model.sv
// user logic model that drives the counter controls
`timescale 1ns/1ps
module fbc_user_model (
	// clock
	input wire logic clk_sys_i,
	// controls to the counter
	output fbc_pkg::fbc_ctrl_t ctrl_o,
	output logic [3:0] load_value_o
);
	initial begin
		ctrl_o = '0;
		load_value_o = 4'h0;
	end
	// called just after an edge; load and the other controls stand until the next call
	task apply(input logic ld, input logic en, input logic up,
		input logic [3:0] v);
		ctrl_o = '{ld, en, up};
		load_value_o = v;
	endtask : apply
endmodule : fbc_user_model

// file: bench/four_bit_updown_counter_test.sv
// self-checking test of the counter, binary and decade variants
`timescale 1ns/1ps
module four_bit_updown_counter_test;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic clear_n_i = 1'b1;
	fbc_pkg::fbc_ctrl_t ctrl;
	logic [3:0] load_value;
	logic [3:0] bin_cnt, dec_cnt, bin_exp, dec_exp;
	logic bin_carry, dec_carry;
	int num_errors = 0;
	int n_compared = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	fbc_user_model fbc_user_model_i (.clk_sys_i(clk_sys_i),
		.ctrl_o(ctrl), .load_value_o(load_value));
	fbc_counter fbc_counter_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.clear_n_i(clear_n_i), .ctrl_i(ctrl), .load_value_i(load_value),
		.count_value_o(bin_cnt), .terminal_count_out_o(bin_carry));
	fbc_counter #(.DECADE(1'b1)) fbc_counter_dec_i (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .clear_n_i(clear_n_i), .ctrl_i(ctrl),
		.load_value_i(load_value), .count_value_o(dec_cnt),
		.terminal_count_out_o(dec_carry));
	function automatic logic [3:0] nxt(logic [3:0] c, logic dec, logic up);
		if (up)
			return (dec && c >= 4'h9) ? 4'h0 : c + 4'h1;
		return (dec && (c == 4'h0 || c > 4'h9)) ? 4'h9 : c - 4'h1;
	endfunction : nxt
	task check(input logic [3:0] got, input logic [3:0] exp,
		input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask : check
	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// one edge of controls; carry checked before the edge, count after
	task step(input logic ld, input logic en, input logic up,
		input logic [3:0] v);
		logic bc;
		logic dc;
		bc = en & ~ld & (up ? bin_exp == 4'hf : bin_exp == 4'h0);
		dc = en & ~ld & up & (dec_exp == 4'h9);
		fbc_user_model_i.apply(ld, en, up, v);
		#20;
		check({3'h0, bin_carry}, {3'h0, bc}, "bin carry");
		check({3'h0, dec_carry}, {3'h0, dc}, "dec carry");
		@(posedge clk_sys_i);
		#1;
		bin_exp = ld ? v : en ? nxt(bin_exp, 1'b0, up) : bin_exp;
		dec_exp = ld ? v : en ? nxt(dec_exp, 1'b1, up) : dec_exp;
		check(bin_cnt, bin_exp, "bin count");
		check(dec_cnt, dec_exp, "dec count");
	endtask : step
	initial begin
		#20000;
		num_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end
	initial begin
		bin_exp = 4'h0;
		dec_exp = 4'h0;
		repeat (10) @(posedge clk_sys_i);
		#1;
		reset_i = 1'b0;
		check(bin_cnt, 4'h0, "reset count");
		repeat (18) step(1'b0, 1'b1, 1'b1, 4'h0);
		$display("test count up done");
		repeat (18) step(1'b0, 1'b1, 1'b0, 4'h0);
		$display("test count down done");
		for (int i = 0; i < 4; i++) begin
			step(1'b1, 1'b0, i[0], 4'h1 << i);
			step(1'b0, 1'b0, 1'b1, 4'h0);
			step(1'b0, 1'b1, i[1], 4'h0);
		end
		$display("test load and hold done");
		step(1'b1, 1'b1, 1'b1, 4'h9);
		fbc_user_model_i.apply(1'b0, 1'b1, 1'b1, 4'h0);
		#10;
		clear_n_i = 1'b0;
		#5;
		check(bin_cnt, 4'h0, "clear bin");
		check(dec_cnt, 4'h0, "clear dec");
		check({3'h0, dec_carry}, 4'h0, "clear carry");
		check({3'h0, bin_carry}, 4'h0, "clear bin carry");
		@(posedge clk_sys_i);
		#1;
		clear_n_i = 1'b1;
		bin_exp = 4'h0;
		dec_exp = 4'h0;
		repeat (3) step(1'b0, 1'b1, 1'b1, 4'h0);
		$display("test clear done");
		conclude();
	end
endmodule : four_bit_updown_counter_test
